//--- inc/selfprog_pkg.sv
// Purpose: Shared constants for the self-programming control block
// Assumes: 15-bit word program counter, 128-word pages
// Notes: Flash array timing is modelled by a busy count only
package selfprog_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] CSR_ADDR = 8'h37;
    localparam logic [7:0] CSR_RESET = 8'h00;
    localparam int BIT_IRQ_EN = 7;
    localparam int BIT_BUSY = 6;
    localparam int BIT_SIG = 5;
    localparam int BIT_REEN = 4;
    localparam int BIT_LOCK = 3;
    localparam int BIT_PGWR = 2;
    localparam int BIT_PGER = 1;
    localparam int BIT_SEN = 0;
    // Legal lower-five-bit patterns, plus the six-bit signature pattern
    localparam logic [4:0] PAT_REEN = 5'h11;
    localparam logic [4:0] PAT_LOCK = 5'h09;
    localparam logic [4:0] PAT_PGWR = 5'h05;
    localparam logic [4:0] PAT_PGER = 5'h03;
    localparam logic [4:0] PAT_FILL = 5'h01;
    localparam logic [5:0] PAT_SIG = 6'h21;
    // ------------------------------------------------------------
    // Flash geometry
    // ------------------------------------------------------------
    localparam int PC_W = 15;
    localparam int WORD_W = 7;
    localparam int PAGE_W = PC_W - WORD_W;
    localparam int Z_W = 16;
    localparam logic [PC_W-1:0] RWW_LAST = 15'h6fff;
    localparam logic [PC_W-1:0] BOOT_11 = 15'h7e00;
    localparam logic [PC_W-1:0] BOOT_10 = 15'h7c00;
    localparam logic [PC_W-1:0] BOOT_01 = 15'h7800;
    localparam logic [PC_W-1:0] BOOT_00 = 15'h7000;
    localparam logic [PAGE_W-1:0] RWW_PAGES = 8'he0;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam logic [2:0] ARM_CYCLES = 3'h4;
    localparam logic [2:0] LOAD_CYCLES = 3'h3;
    localparam int CLK_MHZ = 25;
    localparam int PROG_US = 4;
    localparam int PROG_CYCLES = PROG_US * CLK_MHZ;
    // ------------------------------------------------------------
    // Store-side commands
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_NONE = 3'b000,
        CMD_FILL = 3'b001,
        CMD_ERASE = 3'b010,
        CMD_WRITE = 3'b011,
        CMD_LOCK = 3'b100,
        CMD_REEN = 3'b101,
        CMD_SIG = 3'b110
    } cmd_e;

    function automatic logic [PC_W-1:0] boot_start(input logic [1:0] sel);
        case (sel)
            2'b11: boot_start = BOOT_11;
            2'b10: boot_start = BOOT_10;
            2'b01: boot_start = BOOT_01;
            default: boot_start = BOOT_00;
        endcase
    endfunction : boot_start

    function automatic logic in_halting(input logic [PAGE_W-1:0] page);
        in_halting = page >= RWW_PAGES;
    endfunction : in_halting
endpackage : selfprog_pkg

//--- inc/selfprog_if.sv
// Purpose: Core-to-controller link for self-programming
// Assumes: One clock, core drives instruction strobes
// Notes: No clocking block
`timescale 1ns/1ps
interface selfprog_if;
    logic csr_we;
    logic [7:0] csr_wdata;
    logic [7:0] csr_rdata;
    logic spm_req;
    logic lpm_req;
    logic [15:0] zptr;
    logic [15:0] data_reg_pair;
    logic [7:0] lpm_data;
    logic lpm_valid;
    logic core_stall;
    logic irq_req;
    logic global_irq_en;
    modport ctrl(
        input csr_we, csr_wdata, spm_req, lpm_req, zptr, data_reg_pair, global_irq_en,
        output csr_rdata, lpm_data, lpm_valid, core_stall, irq_req
    );
    modport core(
        output csr_we, csr_wdata, spm_req, lpm_req, zptr, data_reg_pair, global_irq_en,
        input csr_rdata, lpm_data, lpm_valid, core_stall, irq_req
    );
endinterface : selfprog_if

//--- src/self_programming_control.sv
// Purpose: Self-programming control and status register and command sequencer
// Assumes: Core issues store/load program memory instructions as one-cycle strobes
// Notes: Flash array is external; controller issues one-cycle flash commands
//
// Functional notes
// [RULE1] Boot size selects region at flash top
// [RULE2] Lower 224 pages concurrent, upper 32 halting
// [RULE3] 15-bit PC, 128-word pages
// [RULE4] Pointer 7:1 selects word, zero for write
// [RULE5] Pointer bit 0 ignored by stores
// [RULE6] Interrupt while enabled, global set, store clear
// [RULE7] Erase/write on concurrent region sets busy
// [RULE8] Busy clears on re-enable or buffer load
// [RULE9] Signature read: load returns signature, store ignored
// [RULE10] Re-enable via store within four cycles
// [RULE11] Re-enable during buffer load aborts load
// [RULE12] Lock-set programs lock bits from low data
// [RULE13] Load after lock-set returns lock or fuse
// [RULE14] Page write writes buffer to page
// [RULE15] Page erase erases addressed page
// [RULE16] Core stalled when halting region programmed
// [RULE17] Store enable arms four cycles; fill buffer
// [RULE18] Store enable clears, held during erase/write
// [RULE19] Only five legal patterns arm a command
// [RULE20] Only one store instruction active at once
// [RULE21] Register resets to zero; bit 6 read-only
// [RULE22] Store without enable does nothing
// [RULE23] Window counts from next cycle, clears bits 5:0
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
module self_programming_control
    import selfprog_pkg::*;
#(
    parameter int PROG_TIME = selfprog_pkg::PROG_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Core link
    selfprog_if.ctrl link,
    // Strap and fixed data
    input wire logic [1:0] boot_size_select,
    input wire logic [7:0] lock_bits,
    input wire logic [7:0] fuse_bits,
    input wire logic [7:0] sig_byte,
    // Flash array
    output logic flash_fill,
    output logic flash_erase,
    output logic flash_write,
    output logic flash_lock,
    output logic flash_abort,
    output logic [selfprog_pkg::PAGE_W-1:0] page_index,
    output logic [selfprog_pkg::WORD_W-1:0] word_in_page,
    output logic [15:0] flash_data,
    output logic [selfprog_pkg::PC_W-1:0] boot_start_addr,
    output logic concurrent_blocked
);
    import selfprog_pkg::*;

    logic [7:0] csr;
    logic [2:0] arm_cnt;
    logic [15:0] busy_cnt;
    logic prog_active;
    logic halting_op;
    logic legal_wr;
    logic spm_ok;
    logic lpm_ok;
    logic [4:0] low5;
    logic [1:0] boot_meta;
    logic [1:0] boot_sync;

    assign low5 = link.csr_wdata[4:0];
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    assign legal_wr = low5 == PAT_REEN || low5 == PAT_LOCK || low5 == PAT_PGWR
        || low5 == PAT_PGER || low5 == PAT_FILL; // [RULE19]
    assign spm_ok = link.spm_req && csr[BIT_SEN] && !prog_active && arm_cnt != 3'h0; // [RULE22] [RULE20]
    assign lpm_ok = link.lpm_req && csr[BIT_SEN] && arm_cnt > ARM_CYCLES - LOAD_CYCLES;

    // ------------------------------------------------------------
    // Control and status register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            csr <= CSR_RESET; // [RULE21]
        end else begin
            if (link.csr_we) begin
                csr[BIT_IRQ_EN] <= link.csr_wdata[BIT_IRQ_EN];
                if (!prog_active && (legal_wr || link.csr_wdata[BIT_SIG:BIT_SEN] == PAT_SIG)) begin
                    csr[BIT_SIG:BIT_SEN] <= link.csr_wdata[BIT_SIG:BIT_SEN]; // [RULE19] [RULE9]
                end
                if (link.csr_wdata[BIT_REEN] && csr[BIT_SEN] && !prog_active) begin
                    csr[BIT_SIG:BIT_SEN] <= 6'h00; // [RULE11]
                end
            end else if (spm_ok) begin
                if (csr[BIT_PGWR] || csr[BIT_PGER]) begin
                    csr[BIT_SIG:BIT_SEN+1] <= csr[BIT_SIG:BIT_SEN+1]; // [RULE18]
                end else begin
                    csr[BIT_SIG:BIT_SEN] <= 6'h00; // [RULE17] [RULE18]
                end
            end else if (prog_active && busy_cnt == 16'h0001) begin
                csr[BIT_SIG:BIT_SEN] <= 6'h00; // [RULE14] [RULE15] [RULE18]
            end else if (!prog_active && arm_cnt == 3'h1) begin
                csr[BIT_SIG:BIT_SEN] <= 6'h00; // [RULE23] [RULE12]
            end
            if (spm_ok && (csr[BIT_PGWR] || csr[BIT_PGER]) && !in_halting(link.zptr[15:8])) begin
                csr[BIT_BUSY] <= 1'b1; // [RULE7] [RULE2]
            end else if (spm_ok && (csr[BIT_REEN] || (csr[4:0] == PAT_FILL && !csr[BIT_SIG]))) begin
                csr[BIT_BUSY] <= 1'b0; // [RULE8] [RULE10]
            end
        end
    end

    // ------------------------------------------------------------
    // Arming window
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            arm_cnt <= 3'h0;
        end else if (link.csr_we && !prog_active && legal_wr) begin
            arm_cnt <= ARM_CYCLES; // [RULE23] [RULE17]
        end else if (spm_ok) begin
            arm_cnt <= 3'h0;
        end else if (arm_cnt != 3'h0) begin
            arm_cnt <= arm_cnt - 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Boot size strap synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            boot_meta <= 2'h0;
            boot_sync <= 2'h0;
        end else begin
            boot_meta <= boot_size_select;
            boot_sync <= boot_meta;
        end
    end

    // ------------------------------------------------------------
    // Page operation timer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prog_active <= 1'b0;
            busy_cnt <= 16'h0000;
            halting_op <= 1'b0;
        end else if (spm_ok && (csr[BIT_PGWR] || csr[BIT_PGER])) begin
            prog_active <= 1'b1;
            busy_cnt <= 16'(PROG_TIME);
            halting_op <= in_halting(link.zptr[15:8]); // [RULE16]
        end else if (prog_active) begin
            busy_cnt <= busy_cnt - 16'h0001;
            if (busy_cnt == 16'h0001) begin
                prog_active <= 1'b0;
                halting_op <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Flash commands
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flash_fill <= 1'b0;
            flash_erase <= 1'b0;
            flash_write <= 1'b0;
            flash_lock <= 1'b0;
            flash_abort <= 1'b0;
            page_index <= '0;
            word_in_page <= '0;
            flash_data <= 16'h0000;
        end else begin
            flash_fill <= spm_ok && csr[4:0] == PAT_FILL && !csr[BIT_SIG]; // [RULE17]
            flash_erase <= spm_ok && csr[BIT_PGER]; // [RULE15]
            flash_write <= spm_ok && csr[BIT_PGWR]; // [RULE14]
            flash_lock <= spm_ok && csr[BIT_LOCK]; // [RULE12]
            flash_abort <= link.csr_we && link.csr_wdata[BIT_REEN] && csr[BIT_SEN] && !prog_active; // [RULE11]
            if (spm_ok) begin
                page_index <= link.zptr[15:8]; // [RULE3]
                word_in_page <= csr[BIT_PGWR] ? '0 : link.zptr[7:1]; // [RULE4] [RULE5]
                flash_data <= csr[BIT_LOCK] ? {8'h00, link.data_reg_pair[7:0]} : link.data_reg_pair;
            end
        end
    end

    // ------------------------------------------------------------
    // Load answers, stall, interrupt, read-back
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            link.lpm_valid <= 1'b0;
            link.lpm_data <= 8'h00;
        end else begin
            link.lpm_valid <= lpm_ok && (csr[BIT_SIG] || csr[BIT_LOCK]);
            if (lpm_ok && csr[BIT_SIG]) begin
                link.lpm_data <= sig_byte; // [RULE9]
            end else if (lpm_ok && csr[BIT_LOCK]) begin
                link.lpm_data <= link.zptr[0] ? fuse_bits : lock_bits; // [RULE13] [RULE5]
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            link.core_stall <= 1'b0;
            link.irq_req <= 1'b0;
            link.csr_rdata <= CSR_RESET;
            boot_start_addr <= BOOT_00;
            concurrent_blocked <= 1'b0;
        end else begin
            link.core_stall <= (spm_ok && (csr[BIT_PGWR] || csr[BIT_PGER]) && in_halting(link.zptr[15:8]))
                || (halting_op && busy_cnt != 16'h0001); // [RULE16]
            link.irq_req <= csr[BIT_IRQ_EN] && link.global_irq_en && !csr[BIT_SEN]; // [RULE6]
            link.csr_rdata <= csr;
            boot_start_addr <= boot_start(boot_sync); // [RULE1]
            concurrent_blocked <= csr[BIT_BUSY]; // [RULE7]
        end
    end
endmodule : self_programming_control

//--- src/selfprog_core_port.sv
// Purpose: Core-side end issuing register writes and program memory instructions
// Assumes: Software orders arrive on a plain register port
// Notes: Register 0 order, 1 zptr, 2 data pair, 3 status
`timescale 1ns/1ps
module selfprog_core_port
    import selfprog_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Software port
    input wire logic [1:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    // Controller link
    selfprog_if.core link
);
    import selfprog_pkg::*;

    logic [15:0] last_lpm;

    // ------------------------------------------------------------
    // Orders: 0 csr write, bit 8 store, bit 9 load, bit 10 gie
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            link.csr_we <= 1'b0;
            link.csr_wdata <= 8'h00;
            link.spm_req <= 1'b0;
            link.lpm_req <= 1'b0;
            link.zptr <= 16'h0000;
            link.data_reg_pair <= 16'h0000;
            link.global_irq_en <= 1'b0;
        end else begin
            link.csr_we <= wr && addr == 2'h0 && wdata[15:8] == 8'h00;
            link.spm_req <= wr && addr == 2'h0 && wdata[8] && !link.core_stall; // [RULE20]
            link.lpm_req <= wr && addr == 2'h0 && wdata[9];
            if (wr && addr == 2'h0 && wdata[15:8] == 8'h00) begin
                link.csr_wdata <= wdata[7:0];
            end
            if (wr && addr == 2'h0 && wdata[10]) begin
                link.global_irq_en <= wdata[0];
            end
            if (wr && addr == 2'h1) begin
                link.zptr <= wdata; // [RULE5]
            end
            if (wr && addr == 2'h2) begin
                link.data_reg_pair <= wdata;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            last_lpm <= 16'h0000;
            rdata <= 16'h0000;
        end else begin
            if (link.lpm_valid) begin
                last_lpm <= {8'h01, link.lpm_data};
            end
            if (rd) begin
                case (addr)
                    2'h0: rdata <= {8'h00, link.csr_rdata};
                    2'h1: rdata <= link.zptr;
                    2'h2: rdata <= last_lpm;
                    default: rdata <= {14'h0000, link.irq_req, link.core_stall};
                endcase
            end else begin
                rdata <= 16'h0000;
            end
        end
    end
endmodule : selfprog_core_port

//--- verification/selfprog_properties.sv
// Purpose: Concurrent checks on the core-to-controller link
// Assumes: One clock, asynchronous active-high reset
// Notes: csr_rdata lags the register by one cycle
`timescale 1ns/1ps
module selfprog_properties #(
    parameter int PROG_TIME = 100
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Link signals
    input wire logic csr_we,
    input wire logic [7:0] csr_wdata,
    input wire logic [7:0] csr_rdata,
    input wire logic spm_req,
    input wire logic lpm_req,
    input wire logic [15:0] zptr,
    input wire logic [15:0] data_reg_pair,
    input wire logic [7:0] lpm_data,
    input wire logic lpm_valid,
    input wire logic core_stall,
    input wire logic irq_req,
    input wire logic global_irq_en
);
    logic [15:0] stall_cnt;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stall_cnt <= 16'h0000;
        end else if (core_stall) begin
            stall_cnt <= stall_cnt + 16'h0001;
        end else begin
            stall_cnt <= 16'h0000;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_irq_follows_csr: assert property (
        irq_req == (csr_rdata[7] && $past(global_irq_en) && !csr_rdata[0])) else $error("irq level wrong");
    a_busy_from_store: assert property (
        $rose(csr_rdata[6]) |-> $past(spm_req, 2)) else $error("busy set without store");
    a_stall_from_store: assert property (
        $rose(core_stall) |-> $past(spm_req)) else $error("stall without store");
    a_stall_length: assert property (
        $fell(core_stall) |-> stall_cnt == 16'(PROG_TIME)) else $error("stall length wrong");
    a_load_answer: assert property (
        lpm_valid |-> $past(lpm_req)) else $error("load answer without load");
    a_window_expiry: assert property (
        (csr_we && csr_wdata[4:0] == 5'h05 && !csr_rdata[0]) ##1 (!spm_req && !csr_we)[*4]
        |=> csr_rdata[2] ##1 csr_rdata[2:0] == 3'b000) else $error("arming window wrong");
    a_idle_store_noop: assert property (
        (spm_req && !csr_we && csr_rdata == 8'h00 && !$past(csr_we) && !$past(csr_we, 2))
        |=> !core_stall ##1 csr_rdata == 8'h00) else $error("idle store had effect");
    a_busy_write_ignored: assert property (
        (csr_we && csr_wdata[6] && !csr_rdata[6] && !spm_req && !$past(spm_req) && !$past(spm_req, 2))
        |-> ##2 !csr_rdata[6]) else $error("busy bit written");
    c_stall: cover property ($rose(core_stall));
    c_load: cover property (lpm_valid);
    c_busy: cover property ($rose(csr_rdata[6]));
endmodule : selfprog_properties

//--- verification/tb_self_programming_control.sv
// Purpose: Self-checking bench for both ends of the self-programming link
// Assumes: Software port drives the core end; straps driven here
// Notes: Programming time shortened to 8 cycles
`timescale 1ns/1ps
module tb_self_programming_control;
    import selfprog_pkg::*;
    localparam int PT = 8;
    localparam logic [14:0] BOOT_EXP [4] = '{15'h7000, 15'h7800, 15'h7c00, 15'h7e00};
    localparam logic [7:0] BAD_PAT [4] = '{8'h02, 8'h1f, 8'h0d, 8'h40};
    logic clk_sys, rst, wr, rd;
    logic [1:0] addr, boot_size_select;
    logic [15:0] wdata, rdata, flash_data, rv;
    logic [7:0] lock_bits, fuse_bits, sig_byte;
    logic flash_fill, flash_erase, flash_write, flash_lock, flash_abort, concurrent_blocked;
    logic [PAGE_W-1:0] page_index;
    logic [WORD_W-1:0] word_in_page;
    logic [PC_W-1:0] boot_start_addr;
    logic [5:0] evt;
    int bad_count, n_checks;
    selfprog_if link();
    assign evt = {flash_abort, link.lpm_valid, flash_lock, flash_write, flash_erase, flash_fill};
    self_programming_control #(.PROG_TIME(PT)) u_self_programming_control (.clk_sys(clk_sys), .rst(rst),
        .link(link), .boot_size_select(boot_size_select), .lock_bits(lock_bits), .fuse_bits(fuse_bits),
        .sig_byte(sig_byte), .flash_fill(flash_fill), .flash_erase(flash_erase), .flash_write(flash_write),
        .flash_lock(flash_lock), .flash_abort(flash_abort), .page_index(page_index),
        .word_in_page(word_in_page), .flash_data(flash_data), .boot_start_addr(boot_start_addr),
        .concurrent_blocked(concurrent_blocked));
    selfprog_core_port u_selfprog_core_port (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .link(link));
    selfprog_properties #(.PROG_TIME(PT)) u_selfprog_properties (.clk_sys(clk_sys), .rst(rst),
        .csr_we(link.csr_we), .csr_wdata(link.csr_wdata), .csr_rdata(link.csr_rdata), .spm_req(link.spm_req),
        .lpm_req(link.lpm_req), .zptr(link.zptr), .data_reg_pair(link.data_reg_pair), .lpm_data(link.lpm_data),
        .lpm_valid(link.lpm_valid), .core_stall(link.core_stall), .irq_req(link.irq_req),
        .global_irq_en(link.global_irq_en));
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [1:0] a, output logic [15:0] d);
        repeat (3) @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        @(negedge clk_sys);
        d = rdata;
    endtask : rd_reg
    task automatic wait_evt(input int idx);
        int n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (evt[idx] !== 1'b1 && n < 40);
        if (evt[idx] !== 1'b1) begin
            bad_count++;
            $display("[ERR] event %0d expected 1 seen 0", idx);
            final_report();
        end
    endtask : wait_evt
    task automatic quiet(input string what);
        repeat (5) begin
            @(negedge clk_sys);
            chk(what, 16'h0000, {10'h000, evt});
        end
    endtask : quiet
    task automatic wait_idle();
        int n = 0;
        do begin
            rd_reg(2'd0, rv);
            n++;
        end while (rv[0] !== 1'b0 && n < 20);
        if (rv[0] !== 1'b0) begin
            bad_count++;
            $display("[ERR] store enable expected 0 seen 1");
            final_report();
        end
    endtask : wait_idle
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    initial begin
        rst = 1'b1;
        {wr, rd, addr, wdata, boot_size_select} = '0;
        {lock_bits, fuse_bits, sig_byte} = 24'h3cd95a;
        bad_count = 0;
        n_checks = 0;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        rd_reg(2'd0, rv);
        chk("csr reset", 16'h0000, rv);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            boot_size_select <= 2'(i);
            repeat (4) @(negedge clk_sys);
            chk("boot start", {1'b0, BOOT_EXP[i]}, {1'b0, boot_start_addr});
        end
        foreach (BAD_PAT[i]) begin
            wr_reg(2'd0, {8'h00, BAD_PAT[i]});
            rd_reg(2'd0, rv);
            chk("csr refused", 16'h0000, rv);
        end
        wr_reg(2'd0, 16'h0100);
        quiet("idle store");
        $display("test reset and refusals done");
        wr_reg(2'd1, 16'h12fe);
        rd_reg(2'd1, rv);
        chk("pointer", 16'h12fe, rv);
        wr_reg(2'd2, 16'ha5c3);
        wr_reg(2'd0, 16'h0001);
        wr_reg(2'd0, 16'h0100);
        wait_evt(0);
        chk("fill word", 16'h007f, 16'(word_in_page));
        chk("fill data", 16'ha5c3, flash_data);
        rd_reg(2'd0, rv);
        chk("csr after fill", 16'h0000, rv);
        wr_reg(2'd0, 16'h0005);
        repeat (8) @(posedge clk_sys);
        rd_reg(2'd0, rv);
        chk("csr expired", 16'h0000, rv);
        wr_reg(2'd0, 16'h0001);
        wr_reg(2'd0, 16'h0011);
        wait_evt(5);
        rd_reg(2'd0, rv);
        chk("csr after abort", 16'h0000, rv & 16'h001f);
        $display("test fill, expiry and abort done");
        wr_reg(2'd1, 16'h1000);
        wr_reg(2'd0, 16'h0003);
        wr_reg(2'd0, 16'h0100);
        wait_evt(1);
        chk("erase page", 16'h0010, 16'(page_index));
        chk("erase stall", 16'h0000, 16'(link.core_stall));
        rd_reg(2'd0, rv);
        chk("csr erasing", 16'h0043, rv);
        chk("blocked", 16'h0001, 16'(concurrent_blocked));
        wait_idle();
        chk("csr erased", 16'h0040, rv);
        wr_reg(2'd0, 16'h0011);
        wr_reg(2'd0, 16'h0100);
        rd_reg(2'd0, rv);
        chk("csr reenabled", 16'h0000, rv);
        wr_reg(2'd1, 16'he000);
        wr_reg(2'd0, 16'h0005);
        wr_reg(2'd0, 16'h0100);
        wait_evt(2);
        chk("write page", 16'h00e0, 16'(page_index));
        chk("write word", 16'h0000, 16'(word_in_page));
        chk("write stall", 16'h0001, 16'(link.core_stall));
        wait_idle();
        chk("csr written", 16'h0000, rv);
        $display("test erase and write done");
        wr_reg(2'd2, 16'hffc5);
        wr_reg(2'd0, 16'h0009);
        wr_reg(2'd0, 16'h0100);
        wait_evt(3);
        chk("lock data", 16'h00c5, flash_data);
        wr_reg(2'd0, 16'h0009);
        wr_reg(2'd0, 16'h0200);
        wait_evt(4);
        chk("lock read", {8'h00, lock_bits}, {8'h00, link.lpm_data});
        wr_reg(2'd0, 16'h0021);
        wr_reg(2'd0, 16'h0200);
        wait_evt(4);
        chk("sig read", {8'h00, sig_byte}, {8'h00, link.lpm_data});
        rd_reg(2'd2, rv);
        chk("load latch", {8'h01, sig_byte}, rv);
        wr_reg(2'd0, 16'h0021);
        wr_reg(2'd0, 16'h0100);
        quiet("sig store");
        wr_reg(2'd1, 16'he001);
        wr_reg(2'd0, 16'h0009);
        wr_reg(2'd0, 16'h0200);
        wait_evt(4);
        chk("fuse read", {8'h00, fuse_bits}, {8'h00, link.lpm_data});
        $display("test lock and signature done");
        wr_reg(2'd0, 16'h0401);
        wr_reg(2'd0, 16'h0080);
        rd_reg(2'd3, rv);
        chk("irq on", 16'h0002, rv);
        wr_reg(2'd0, 16'h0081);
        repeat (3) @(negedge clk_sys);
        chk("irq masked", 16'h0000, 16'(link.irq_req));
        wr_reg(2'd0, 16'h0400);
        rd_reg(2'd3, rv);
        chk("irq off", 16'h0000, rv);
        $display("test interrupt done");
        final_report();
    end
endmodule : tb_self_programming_control
